// ---- core/ssec_ctrl.v ----
`timescale 1ns/1ps
`include "ssec_regs.vh"

module ssec_ctrl #(
    parameter SYNC_MIN_CYC = `SSEC_SYNC_MIN_CYC,
    parameter PULSE_HALF_CYC = `SSEC_PULSE_HALF_CYC,
    parameter STEP_GAP_CYC = `SSEC_STEP_GAP_CYC
) (
    input wire clk_sys_i,
    input wire arst_n_i,
    input wire ce_i,
    input wire spi_cs_n_i,
    input wire spi_sclk_i,
    input wire spi_sdi_i,
    output wire spi_sdo_o,
    output wire spi_sdo_oe_n_o,
    input wire sync_pin_i,
    input wire loop1_lock_i,
    input wire loop2_lock_i,
    input wire clock_input_zero_i,
    output reg ref_port_power_down_o,
    output reg sysref_global_power_down_o,
    output reg sysref_block_power_down_o,
    output reg sysref_delay_power_down_o,
    output reg pulser_power_down_o,
    output reg sysref_clear_o,
    output reg [1:0] sysref_source_select_o,
    output reg sync_active_o,
    output reg sysref_sync_hold_o,
    output reg [6:0] clock_sync_hold_o,
    output reg sysref_pulse_o,
    output reg [7:0] dyn_delay_step_o,
    output reg loop1_refdiv_sync_o,
    output reg loop2_refdiv_sync_o,
    output reg aux_input_halve_o
);
    localparam P_IDLE = 2'h0;
    localparam P_HIGH = 2'h1;
    localparam P_LOW = 2'h2;

    wire wr;
    wire [`SSEC_ADDR_W-1:0] addr;
    wire [7:0] wdata;
    reg [7:0] rd_data;

    reg [1:0] src_sel_ff;
    reg [1:0] pulse_cnt_ff;
    reg [4:0] power_down_ff;
    reg [7:0] dyn_delay_enable_ff;
    reg [7:0] dyn_delay_step_count_ff;
    reg [7:0] sync_control_ff;
    reg [7:0] sync_exclude_mask_ff;
    reg [7:0] ref_divider_sync_config_ff;

    reg pin_meta_ff;
    reg pin_sync_ff;
    reg req_prev_ff;
    reg pin_prev_ff;
    reg [7:0] hold_cnt_ff;
    reg [1:0] pls_state_ff;
    reg [3:0] pls_left_ff;
    reg [7:0] pls_timer_ff;
    reg [7:0] steps_left_ff;
    reg [7:0] gap_cnt_ff;

    ssec_spi_port u_spi (
        .clk_sys_i(clk_sys_i),
        .arst_n_i(arst_n_i),
        .ce_i(ce_i),
        .spi_cs_n_i(spi_cs_n_i),
        .spi_sclk_i(spi_sclk_i),
        .spi_sdi_i(spi_sdi_i),
        .rd_data_i(rd_data),
        .spi_sdo_o(spi_sdo_o),
        .spi_sdo_oe_n_o(spi_sdo_oe_n_o),
        .wr_o(wr),
        .addr_o(addr),
        .wdata_o(wdata)
    );

    // field decode
    wire [1:0] mode = sync_control_ff[`SSEC_SC_MODE_HI:`SSEC_SC_MODE_LO];
    wire blk_pd = power_down_ff[`SSEC_PD_SYSREF_BLK];
    // no sync and no pulser while the sysref block is down
    wire sync_on = sync_control_ff[`SSEC_SC_ENABLE] & ~blk_pd;
    wire wr_pulse_cnt = wr && addr == `SSEC_OFF_PULSE_CNT;
    wire wr_steps = wr && addr == `SSEC_OFF_DDLY_STEPS;

    // software register writes
    always @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            src_sel_ff <= `SSEC_RST_SRC_SEL;
            pulse_cnt_ff <= `SSEC_RST_PULSE_CNT;
            power_down_ff <= `SSEC_RST_POWER_DOWN;
            dyn_delay_enable_ff <= `SSEC_RST_DDLY_EN;
            dyn_delay_step_count_ff <= `SSEC_RST_DDLY_STEPS;
            sync_control_ff <= `SSEC_RST_SYNC_CTRL;
            sync_exclude_mask_ff <= `SSEC_RST_SYNC_EXCL;
            ref_divider_sync_config_ff <= `SSEC_RST_REFDIV_SYNC;
        end else if (ce_i && wr) begin
            case (addr)
                `SSEC_OFF_SRC_SEL: src_sel_ff <= wdata[1:0];
                `SSEC_OFF_PULSE_CNT: pulse_cnt_ff <= wdata[1:0];
                `SSEC_OFF_POWER_DOWN: power_down_ff <= wdata[4:0];
                `SSEC_OFF_DDLY_EN: dyn_delay_enable_ff <= wdata;
                `SSEC_OFF_DDLY_STEPS: dyn_delay_step_count_ff <= wdata;
                `SSEC_OFF_SYNC_CTRL: sync_control_ff <= wdata;
                `SSEC_OFF_SYNC_EXCL: sync_exclude_mask_ff <= wdata;
                // bits 1:0 belong to the input buffer, not to this block
                `SSEC_OFF_REFDIV_SYNC: ref_divider_sync_config_ff <= {1'b0, wdata[6:2], 2'h0};
                default: ;
            endcase
        end
    end

    // read mux; unmapped addresses read zero
    always @* begin
        case (addr)
            `SSEC_OFF_SRC_SEL: rd_data = {6'h00, src_sel_ff};
            `SSEC_OFF_PULSE_CNT: rd_data = {6'h00, pulse_cnt_ff};
            `SSEC_OFF_POWER_DOWN: rd_data = {3'h0, power_down_ff};
            `SSEC_OFF_DDLY_EN: rd_data = dyn_delay_enable_ff;
            `SSEC_OFF_DDLY_STEPS: rd_data = dyn_delay_step_count_ff;
            `SSEC_OFF_SYNC_CTRL: rd_data = sync_control_ff;
            `SSEC_OFF_SYNC_EXCL: rd_data = sync_exclude_mask_ff;
            `SSEC_OFF_REFDIV_SYNC: rd_data = ref_divider_sync_config_ff;
            default: rd_data = 8'h00;
        endcase
    end

    // pin synchroniser; only the second stage is looked at
    always @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            pin_meta_ff <= 1'b0;
            pin_sync_ff <= 1'b0;
        end else if (ce_i) begin
            pin_meta_ff <= sync_pin_i;
            pin_sync_ff <= pin_meta_ff;
        end
    end

    // polarity after synchronising, so an async edge makes exactly one event
    wire pin_lvl = pin_sync_ff ^ sync_control_ff[`SSEC_SC_INVERT];
    wire pin_rise = pin_lvl & ~pin_prev_ff;
    // lock gating: keep sync asserted while the selected loop is unlocked
    wire lock_hold = (sync_control_ff[`SSEC_SC_HOLD_L1] & ~loop1_lock_i) |
        (sync_control_ff[`SSEC_SC_HOLD_L2] & ~loop2_lock_i);
    wire req_lvl = pin_lvl | lock_hold;
    wire req_rise = req_lvl & ~req_prev_ff;
    wire edge_mode = sync_control_ff[`SSEC_SC_EDGE];
    wire pin_mode = sync_on && mode == `SSEC_MODE_PIN;
    wire pulser_ok = sync_on & ~power_down_ff[`SSEC_PD_PULSER];
    wire trig_pin = pulser_ok && mode == `SSEC_MODE_PULSER_PIN && req_rise;
    wire trig_wr = pulser_ok && mode == `SSEC_MODE_PULSER_WRITE && wr_pulse_cnt;
    // level mode follows the request; edge mode keeps a minimum hold after a rise
    wire sync_now = pin_mode & (edge_mode ? (hold_cnt_ff != 8'h00) | lock_hold :
        req_lvl);

    // edge-mode minimum hold timer
    always @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            pin_prev_ff <= 1'b0;
            req_prev_ff <= 1'b0;
            hold_cnt_ff <= 8'h00;
        end else if (ce_i) begin
            pin_prev_ff <= pin_lvl;
            req_prev_ff <= req_lvl;
            if (pin_mode && edge_mode && pin_rise) begin
                hold_cnt_ff <= SYNC_MIN_CYC[7:0];
            end else if (hold_cnt_ff != 8'h00) begin
                hold_cnt_ff <= hold_cnt_ff - 8'h01;
            end
        end
    end

    // pulser: 1, 2, 4 or 8 pulses per trigger; a trigger while busy is ignored
    always @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            pls_state_ff <= P_IDLE;
            pls_left_ff <= 4'h0;
            pls_timer_ff <= 8'h00;
            sysref_pulse_o <= 1'b0;
        end else if (ce_i) begin
            case (pls_state_ff)
                P_IDLE: begin
                    sysref_pulse_o <= 1'b0;
                    if (trig_pin || trig_wr) begin
                        pls_state_ff <= P_HIGH;
                        // a write in mode 3 uses its own new count
                        pls_left_ff <= 4'h1 << (trig_wr ? wdata[1:0] : pulse_cnt_ff);
                        pls_timer_ff <= PULSE_HALF_CYC[7:0];
                        sysref_pulse_o <= 1'b1;
                    end
                end
                P_HIGH: begin
                    if (pls_timer_ff == 8'h01) begin
                        pls_state_ff <= P_LOW;
                        pls_timer_ff <= PULSE_HALF_CYC[7:0];
                        pls_left_ff <= pls_left_ff - 4'h1;
                        sysref_pulse_o <= 1'b0;
                    end else begin
                        pls_timer_ff <= pls_timer_ff - 8'h01;
                    end
                end
                P_LOW: begin
                    if (pls_timer_ff == 8'h01) begin
                        if (pls_left_ff == 4'h0) begin
                            pls_state_ff <= P_IDLE;
                        end else begin
                            pls_state_ff <= P_HIGH;
                            pls_timer_ff <= PULSE_HALF_CYC[7:0];
                            sysref_pulse_o <= 1'b1;
                        end
                    end else begin
                        pls_timer_ff <= pls_timer_ff - 8'h01;
                    end
                end
                default: begin
                    pls_state_ff <= P_IDLE;
                    sysref_pulse_o <= 1'b0;
                end
            endcase
            // powering down mid-train stops it at once
            if (!pulser_ok) begin
                pls_state_ff <= P_IDLE;
                sysref_pulse_o <= 1'b0;
            end
        end
    end

    // dynamic delay stepping: only a write to the step count starts it
    always @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            steps_left_ff <= 8'h00;
            gap_cnt_ff <= 8'h00;
            dyn_delay_step_o <= 8'h00;
        end else if (ce_i) begin
            dyn_delay_step_o <= 8'h00;
            if (wr_steps) begin
                // a new count restarts in mode 3 and cancels stepping in other modes; zero means no adjustment
                steps_left_ff <= (mode == `SSEC_MODE_PULSER_WRITE) ? wdata : 8'h00;
                gap_cnt_ff <= 8'h00;
            end else if (gap_cnt_ff != 8'h00) begin
                gap_cnt_ff <= gap_cnt_ff - 8'h01;
            end else if (steps_left_ff != 8'h00) begin
                dyn_delay_step_o <= dyn_delay_enable_ff;
                steps_left_ff <= steps_left_ff - 8'h01;
                gap_cnt_ff <= STEP_GAP_CYC[7:0] - 8'h01;
            end
        end
    end

    // registered control and sync outputs
    always @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            ref_port_power_down_o <= 1'b0;
            sysref_global_power_down_o <= 1'b0;
            sysref_block_power_down_o <= 1'b0;
            sysref_delay_power_down_o <= 1'b0;
            pulser_power_down_o <= 1'b0;
            sysref_clear_o <= 1'b0;
            sysref_source_select_o <= 2'h0;
            sync_active_o <= 1'b0;
            sysref_sync_hold_o <= 1'b0;
            clock_sync_hold_o <= 7'h00;
            loop1_refdiv_sync_o <= 1'b0;
            loop2_refdiv_sync_o <= 1'b0;
            aux_input_halve_o <= 1'b0;
        end else if (ce_i) begin
            ref_port_power_down_o <= power_down_ff[`SSEC_PD_REF_PORT];
            // each sysref output applies its own disable mode to this level
            sysref_global_power_down_o <= power_down_ff[`SSEC_PD_SYSREF_GBL];
            sysref_block_power_down_o <= blk_pd;
            sysref_delay_power_down_o <= power_down_ff[`SSEC_PD_SYSREF_DLY];
            pulser_power_down_o <= power_down_ff[`SSEC_PD_PULSER];
            sysref_clear_o <= sync_control_ff[`SSEC_SC_CLEAR];
            sysref_source_select_o <= src_sel_ff;
            sync_active_o <= sync_now;
            sysref_sync_hold_o <= sync_now &
                ~sync_exclude_mask_ff[`SSEC_SYSREF_BIT];
            clock_sync_hold_o <= {7{sync_now}} & ~sync_exclude_mask_ff[6:0];
            // loop1 divider: pin or clock input zero, reserved codes do nothing
            loop1_refdiv_sync_o <= ref_divider_sync_config_ff[`SSEC_RD_L1_EN] &
                ((ref_divider_sync_config_ff[5:4] == `SSEC_RD_SRC_PIN & pin_lvl) |
                (ref_divider_sync_config_ff[5:4] == `SSEC_RD_SRC_CLK0 &
                clock_input_zero_i));
            loop2_refdiv_sync_o <= ref_divider_sync_config_ff[`SSEC_RD_L2_EN] &
                pin_lvl;
            aux_input_halve_o <= ref_divider_sync_config_ff[`SSEC_RD_HALVE];
        end
    end
endmodule // ssec_ctrl

// ---- core/ssec_regs.vh ----
`ifndef SSEC_REGS_VH
`define SSEC_REGS_VH

// register offsets on the serial port (15-bit address space)
`define SSEC_ADDR_W 15
`define SSEC_OFF_SRC_SEL 15'h139
`define SSEC_OFF_PULSE_CNT 15'h13E
`define SSEC_OFF_POWER_DOWN 15'h140
`define SSEC_OFF_DDLY_EN 15'h141
`define SSEC_OFF_DDLY_STEPS 15'h142
`define SSEC_OFF_SYNC_CTRL 15'h143
`define SSEC_OFF_SYNC_EXCL 15'h144
`define SSEC_OFF_REFDIV_SYNC 15'h145

// reset values
`define SSEC_RST_SRC_SEL 2'h0
`define SSEC_RST_PULSE_CNT 2'h3
`define SSEC_RST_POWER_DOWN 5'h00
`define SSEC_RST_DDLY_EN 8'h00
`define SSEC_RST_DDLY_STEPS 8'h00
`define SSEC_RST_SYNC_CTRL 8'h01
`define SSEC_RST_SYNC_EXCL 8'h00
`define SSEC_RST_REFDIV_SYNC 8'h00

// power-down register fields
`define SSEC_PD_REF_PORT 4
`define SSEC_PD_SYSREF_GBL 3
`define SSEC_PD_SYSREF_BLK 2
`define SSEC_PD_SYSREF_DLY 1
`define SSEC_PD_PULSER 0

// sync control fields
`define SSEC_SC_CLEAR 7
`define SSEC_SC_EDGE 6
`define SSEC_SC_INVERT 5
`define SSEC_SC_ENABLE 4
`define SSEC_SC_HOLD_L2 3
`define SSEC_SC_HOLD_L1 2
`define SSEC_SC_MODE_HI 1
`define SSEC_SC_MODE_LO 0

// trigger modes
`define SSEC_MODE_OFF 2'h0
`define SSEC_MODE_PIN 2'h1
`define SSEC_MODE_PULSER_PIN 2'h2
`define SSEC_MODE_PULSER_WRITE 2'h3

// reference divider sync fields
`define SSEC_RD_L1_EN 6
`define SSEC_RD_L1_SRC_HI 5
`define SSEC_RD_L1_SRC_LO 4
`define SSEC_RD_L2_EN 3
`define SSEC_RD_HALVE 2
`define SSEC_RD_SRC_PIN 2'h1
`define SSEC_RD_SRC_CLK0 2'h2

// exclusion / enable masks: bit 7 sysref, bits 6:0 even device clocks
`define SSEC_SYSREF_BIT 7

// timing
`define SSEC_CLK_MHZ 100
`define SSEC_SYNC_MIN_NS 30
`define SSEC_PULSE_HALF_NS 40
`define SSEC_STEP_GAP_NS 80
`define SSEC_SYNC_MIN_CYC ((`SSEC_SYNC_MIN_NS * `SSEC_CLK_MHZ + 999) / 1000)
`define SSEC_PULSE_HALF_CYC ((`SSEC_PULSE_HALF_NS * `SSEC_CLK_MHZ + 999) / 1000)
`define SSEC_STEP_GAP_CYC ((`SSEC_STEP_GAP_NS * `SSEC_CLK_MHZ + 999) / 1000)

`endif

// ---- core/ssec_spi_port.v ----
`timescale 1ns/1ps
`include "ssec_regs.vh"

// serial register port: frame is rw bit, 15 address bits, 8 data bits, msb first
module ssec_spi_port (
    input wire clk_sys_i,
    input wire arst_n_i,
    input wire ce_i,
    input wire spi_cs_n_i,
    input wire spi_sclk_i,
    input wire spi_sdi_i,
    input wire [7:0] rd_data_i,
    output wire spi_sdo_o,
    output wire spi_sdo_oe_n_o,
    output wire wr_o,
    output wire [`SSEC_ADDR_W-1:0] addr_o,
    output wire [7:0] wdata_o
);
    reg sclk_ff;
    reg [22:0] shift_ff;
    reg [4:0] cnt_ff;
    reg rw_ff;
    reg [`SSEC_ADDR_W-1:0] addr_ff;
    reg [7:0] out_ff;
    reg [7:0] wdata_ff;
    reg wr_ff;
    reg oe_n_ff;
    wire sclk_rise = spi_sclk_i & ~sclk_ff;
    wire sclk_fall = ~spi_sclk_i & sclk_ff;

    // sclk is sampled as an ordinary input, so it must run well below clk_sys_i / 4
    always @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            sclk_ff <= 1'b0;
            shift_ff <= 23'h000000;
            cnt_ff <= 5'h00;
            rw_ff <= 1'b0;
            addr_ff <= 15'h0000;
            out_ff <= 8'h00;
            wdata_ff <= 8'h00;
            wr_ff <= 1'b0;
            oe_n_ff <= 1'b1;
        end else if (ce_i) begin
            sclk_ff <= spi_sclk_i;
            wr_ff <= 1'b0;
            if (spi_cs_n_i) begin
                cnt_ff <= 5'h00;
                oe_n_ff <= 1'b1;
            end else if (sclk_rise) begin
                shift_ff <= {shift_ff[21:0], spi_sdi_i};
                if (cnt_ff != 5'h18) begin
                    cnt_ff <= cnt_ff + 5'h01;
                end
                // header complete: latch direction and address
                if (cnt_ff == 5'h0F) begin
                    rw_ff <= shift_ff[14];
                    addr_ff <= {shift_ff[13:0], spi_sdi_i};
                end
                // last data bit of a write frame
                if (cnt_ff == 5'h17 && !rw_ff) begin
                    wdata_ff <= {shift_ff[6:0], spi_sdi_i};
                    wr_ff <= 1'b1;
                end
            end else if (sclk_fall && rw_ff && cnt_ff >= 5'h10) begin
                // read data launched on falling edges for the host's rising edge
                oe_n_ff <= 1'b0;
                if (cnt_ff == 5'h10) begin
                    out_ff <= rd_data_i;
                end else begin
                    out_ff <= {out_ff[6:0], 1'b0};
                end
            end
        end
    end

    assign spi_sdo_o = out_ff[7];
    assign spi_sdo_oe_n_o = oe_n_ff;
    assign wr_o = wr_ff;
    assign addr_o = addr_ff;
    assign wdata_o = wdata_ff;
endmodule // ssec_spi_port

// ---- test/ssec_ctrl_props.sv ----
`timescale 1ns/1ps
// port-level checks
module ssec_ctrl_props (
    input wire clk_sys_i,
    input wire arst_n_i,
    input wire pulser_power_down_o,
    input wire sysref_block_power_down_o,
    input wire sync_active_o,
    input wire sysref_sync_hold_o,
    input wire [6:0] clock_sync_hold_o,
    input wire sysref_pulse_o,
    input wire [7:0] dyn_delay_step_o
);
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!arst_n_i);
    property p_sysref_hold;
        sysref_sync_hold_o |-> sync_active_o;
    endproperty
    a_sysref_hold: assert property (p_sysref_hold)
        else $error("sysref hold without sync");
    property p_clock_hold;
        (clock_sync_hold_o != 7'h00) |-> sync_active_o;
    endproperty
    a_clock_hold: assert property (p_clock_hold)
        else $error("clock hold without sync");
    property p_holds_release;
        $fell(sync_active_o) |-> ##[0:1] (!sysref_sync_hold_o && clock_sync_hold_o == 7'h00);
    endproperty
    a_holds_release: assert property (p_holds_release)
        else $error("holds outlive sync");
    property p_block_pd_quiet;
        sysref_block_power_down_o [*4] |-> !sync_active_o && !sysref_pulse_o;
    endproperty
    a_block_pd_quiet: assert property (p_block_pd_quiet)
        else $error("sync or pulse while sysref block is down");
    property p_pulser_pd_quiet;
        pulser_power_down_o [*2] |-> !sysref_pulse_o;
    endproperty
    a_pulser_pd_quiet: assert property (p_pulser_pd_quiet)
        else $error("pulse while pulser is down");
    // counts assume default timing
    property p_pulse_high;
        $rose(sysref_pulse_o) |-> sysref_pulse_o [*4] ##1 !sysref_pulse_o;
    endproperty
    a_pulse_high: assert property (p_pulse_high)
        else $error("pulse high time wrong");
    property p_pulse_power;
        $rose(sysref_pulse_o) |-> !pulser_power_down_o && !sysref_block_power_down_o;
    endproperty
    a_pulse_power: assert property (p_pulse_power)
        else $error("pulse started while powered down");
    property p_step_gap;
        (dyn_delay_step_o != 8'h00) |=> (dyn_delay_step_o == 8'h00) [*7];
    endproperty
    a_step_gap: assert property (p_step_gap)
        else $error("delay steps too close");
    c_sync: cover property ($rose(sync_active_o));
    c_pulse: cover property ($rose(sysref_pulse_o));
    c_step: cover property (dyn_delay_step_o != 8'h00);
endmodule // ssec_ctrl_props

bind ssec_ctrl ssec_ctrl_props ssec_ctrl_props_inst (
    .clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i), .pulser_power_down_o(pulser_power_down_o),
    .sysref_block_power_down_o(sysref_block_power_down_o), .sync_active_o(sync_active_o),
    .sysref_sync_hold_o(sysref_sync_hold_o), .clock_sync_hold_o(clock_sync_hold_o),
    .sysref_pulse_o(sysref_pulse_o), .dyn_delay_step_o(dyn_delay_step_o)
);

// ---- test/ssec_host_model.sv ----
`timescale 1ns/1ps
// host side: serial register master and sync request pin
module ssec_host_model (
    input wire clk_sys_i,
    input wire spi_sdo_i,
    input wire spi_sdo_oe_n_i,
    output reg spi_cs_n_o,
    output reg spi_sclk_o,
    output reg spi_sdi_o,
    output reg sync_pin_o
);
    reg last_bit;
    // an undriven data line must not read back as a stale value
    wire sdo_line = spi_sdo_oe_n_i ? ~last_bit : spi_sdo_i;
    initial begin
        spi_cs_n_o = 1'b1;
        spi_sclk_o = 1'b0;
        spi_sdi_o = 1'b0;
        sync_pin_o = 1'b0;
        last_bit = 1'b0;
    end
    // frame of rw, 15 address and 8 data bits, msb first; each sclk phase lasts 4 clocks
    task automatic xfer(input logic rw, input logic [14:0] a, input logic [7:0] d,
                        output logic [7:0] rd);
        logic [23:0] frame;
        integer i;
        frame = {rw, a, d};
        rd = 8'h00;
        @(posedge clk_sys_i);
        spi_cs_n_o <= 1'b0;
        repeat (2) @(posedge clk_sys_i);
        for (i = 23; i >= 0; i--) begin
            spi_sclk_o <= 1'b0;
            spi_sdi_o <= frame[i];
            repeat (3) @(posedge clk_sys_i);
            @(negedge clk_sys_i);
            if (i < 8) begin
                rd[i] = sdo_line;
                last_bit = sdo_line;
            end
            @(posedge clk_sys_i);
            spi_sclk_o <= 1'b1;
            repeat (4) @(posedge clk_sys_i);
        end
        spi_sclk_o <= 1'b0;
        repeat (2) @(posedge clk_sys_i);
        spi_cs_n_o <= 1'b1;
        repeat (4) @(posedge clk_sys_i);
    endtask
    task automatic sync_to(input logic v);
        @(posedge clk_sys_i);
        sync_pin_o <= v;
    endtask
endmodule // ssec_host_model

// ---- test/test_sync_sysref_event_control.sv ----
`timescale 1ns/1ps
// register model in an associative array
module test_sync_sysref_event_control;
    logic clk_sys_i = 1'b0, arst_n_i = 1'b0, lock1 = 1'b0, lock2 = 1'b0, clk0 = 1'b1, ce = 1'b1;
    wire cs_n, sclk, sdi, sdo, sdo_oe_n, pin, pd_ref, pd_gbl, pd_blk, pd_dly, pd_pls, clr;
    wire active, sr_hold, pulse, l1_sync, l2_sync, halve;
    wire [1:0] src_sel;
    wire [6:0] clk_hold;
    wire [7:0] step;
    integer failures = 0, compares = 0, np, ns, nh, k;
    logic [7:0] regm [int];
    logic [7:0] m, v;
    logic [14:0] alist [9] = '{15'h139, 15'h13E, 15'h140, 15'h141, 15'h142, 15'h143, 15'h144,
                               15'h145, 15'h150};
    always #5 clk_sys_i = ~clk_sys_i;
    ssec_host_model ssec_host_model_inst (.clk_sys_i(clk_sys_i), .spi_sdo_i(sdo),
        .spi_sdo_oe_n_i(sdo_oe_n), .spi_cs_n_o(cs_n), .spi_sclk_o(sclk), .spi_sdi_o(sdi),
        .sync_pin_o(pin));
    ssec_ctrl ssec_ctrl_inst (.clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i), .ce_i(ce),
        .spi_cs_n_i(cs_n), .spi_sclk_i(sclk), .spi_sdi_i(sdi), .spi_sdo_o(sdo),
        .spi_sdo_oe_n_o(sdo_oe_n), .sync_pin_i(pin), .loop1_lock_i(lock1), .loop2_lock_i(lock2),
        .clock_input_zero_i(clk0), .ref_port_power_down_o(pd_ref),
        .sysref_global_power_down_o(pd_gbl), .sysref_block_power_down_o(pd_blk),
        .sysref_delay_power_down_o(pd_dly), .pulser_power_down_o(pd_pls), .sysref_clear_o(clr),
        .sysref_source_select_o(src_sel), .sync_active_o(active), .sysref_sync_hold_o(sr_hold),
        .clock_sync_hold_o(clk_hold), .sysref_pulse_o(pulse), .dyn_delay_step_o(step),
        .loop1_refdiv_sync_o(l1_sync), .loop2_refdiv_sync_o(l2_sync), .aux_input_halve_o(halve));
    // implemented bits per address; unmapped places read zero
    function automatic logic [7:0] rmask(input logic [14:0] a);
        case (a)
            15'h139, 15'h13E: rmask = 8'h03;
            15'h140: rmask = 8'h1F;
            15'h145: rmask = 8'h7C;
            15'h141, 15'h142, 15'h143, 15'h144: rmask = 8'hFF;
            default: rmask = 8'h00;
        endcase
    endfunction
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] %s expected %0h seen %0h", nm, exp, seen);
        end
    endtask
    task automatic results;
        $display("checks %0d mismatches %0d", compares, failures);
        if (failures == 0 && compares > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic wr(input logic [14:0] a, input logic [7:0] d);
        logic [7:0] rd;
        ssec_host_model_inst.xfer(1'b0, a, d, rd);
        if (rmask(a) != 8'h00) regm[a] = d & rmask(a);
    endtask
    task automatic rdchk(input logic [14:0] a);
        logic [7:0] rd;
        ssec_host_model_inst.xfer(1'b1, a, 8'h00, rd);
        check("read_back", rd, regm.exists(a) ? regm[a] : 8'h00);
    endtask
    // sample on the falling edge so registered outputs have settled
    task automatic watch(input integer n);
        logic prev;
        np = 0;
        ns = 0;
        nh = 0;
        prev = 1'b0;
        repeat (n) begin
            @(negedge clk_sys_i);
            if (pulse === 1'b1 && prev !== 1'b1) np++;
            prev = pulse;
            if (active === 1'b1) nh++;
            if (step !== 8'h00) begin
                ns++;
                check("step_mask", step, regm[15'h141]);
            end
        end
    endtask
    task automatic sync_chk(input logic e);
        repeat (8) @(posedge clk_sys_i);
        @(negedge clk_sys_i);
        check("sync_active", active, e);
        check("sysref_hold", sr_hold, e & ~regm[15'h144][7]);
        check("clock_hold", clk_hold, {7{e}} & ~regm[15'h144][6:0]);
    endtask
    task automatic done(input string nm);
        $display("test %s done", nm);
    endtask
    task automatic pin_to(input logic p);
        ssec_host_model_inst.sync_to(p);
    endtask
    initial begin
        repeat (40000) @(posedge clk_sys_i);
        failures++;
        results();
    end
    initial begin
        void'($urandom(4213));
        foreach (alist[i]) if (rmask(alist[i]) != 8'h00) regm[alist[i]] = 8'h00;
        regm[15'h13E] = 8'h03;
        regm[15'h143] = 8'h01;
        repeat (2) @(posedge clk_sys_i);
        arst_n_i <= 1'b1;
        {lock1, lock2} <= 2'($urandom);
        repeat (3) @(posedge clk_sys_i);
        foreach (alist[i]) rdchk(alist[i]);
        // clear bit stays low outside the setup procedure
        foreach (alist[i]) wr(alist[i], alist[i] == 15'h143 ? $urandom & 8'h7F : $urandom);
        foreach (alist[i]) rdchk(alist[i]);
        check("power_down", {pd_ref, pd_gbl, pd_blk, pd_dly, pd_pls}, regm[15'h140]);
        check("pass_through", {clr, src_sel, halve},
              {regm[15'h143][7], regm[15'h139][1:0], regm[15'h145][2]});
        done("registers");
        wr(15'h140, 8'h00);
        wr(15'h144, $urandom);
        for (k = 0; k < 2; k++) begin
            wr(15'h143, 8'h11 | (k << 5));
            pin_to(~k[0]);
            sync_chk(1'b1);
            pin_to(k[0]);
            sync_chk(1'b0);
        end
        pin_to(1'b0);
        // mode off, sync disabled, block powered down: pin must be ignored
        for (k = 0; k < 3; k++) begin
            wr(15'h140, k == 2 ? 8'h04 : 8'h00);
            wr(15'h143, k == 0 ? 8'h10 : k == 1 ? 8'h01 : 8'h11);
            pin_to(1'b1);
            sync_chk(1'b0);
            pin_to(1'b0);
        end
        wr(15'h140, 8'h00);
        wr(15'h143, 8'h51);
        fork
            pin_to(1'b1);
            watch(40);
        join
        check("edge_hold_cycles", nh, 3);
        pin_to(1'b0);
        for (k = 0; k < 2; k++) begin
            lock1 <= 1'b0;
            lock2 <= 1'b0;
            wr(15'h143, 8'h11 | (8'h04 << k));
            sync_chk(1'b1);
            if (k == 0) lock1 <= 1'b1;
            else lock2 <= 1'b1;
            sync_chk(1'b0);
            wr(15'h143, 8'h11);
        end
        done("sync");
        wr(15'h139, 8'h02);
        wr(15'h143, 8'h13);
        for (k = 0; k < 4; k++) begin
            fork
                wr(15'h13E, k);
                watch(400);
            join
            check("pulses_on_write", np, 1 << k);
        end
        wr(15'h143, 8'h12);
        wr(15'h13E, 8'h01);
        fork
            pin_to(1'b1);
            watch(120);
        join
        check("pulses_on_pin", np, 2);
        pin_to(1'b0);
        wr(15'h143, 8'h13);
        wr(15'h140, 8'h01);
        fork
            wr(15'h13E, 8'h02);
            watch(400);
        join
        check("pulses_powered_down", np, 0);
        wr(15'h140, 8'h00);
        done("pulser");
        wr(15'h141, $urandom | 8'h80);
        for (k = 0; k < 4; k++) begin
            v = k[1] ? (k[0] ? 8'h03 : 8'hFF) : 8'(k);
            if (k == 3) wr(15'h143, 8'h11);
            fork
                wr(15'h142, v);
                watch(v * 8 + 300);
            join
            check("delay_steps", ns, k == 3 ? 0 : v);
        end
        done("dynamic_delay");
        pin_to(1'b1);
        for (k = 0; k < 7; k++) begin
            v = k < 4 ? 8'h40 + (k << 4) : k < 6 ? 8'h04 << (k - 4) : 8'h60;
            clk0 <= k[2];
            wr(15'h145, v);
            @(negedge clk_sys_i);
            m = {v[6] && (v[5:4] == 2'h1 || (v[5:4] == 2'h2 && clk0)), v[3], v[2]};
            check("refdiv_sync", {l1_sync, l2_sync, halve}, m);
        end
        done("refdiv");
        ce <= 1'b0;
        ssec_host_model_inst.xfer(1'b0, 15'h144, ~regm[15'h144], v);
        ce <= 1'b1;
        rdchk(15'h144);
        results();
    end
endmodule // test_sync_sysref_event_control
